// file: dv/ssd_mem_model.sv
// Data memory model standing behind the datapath.
`timescale 1ns/1ps
`default_nettype none
module ssd_mem_model (
  input wire logic i_clk,
  input wire logic i_op_valid,
  input wire logic [2:0] i_addr,
  input wire logic i_mem_wr,
  input wire logic [7:0] i_mem_wdata,
  output logic [7:0] o_mem_rdata
);
  logic [7:0] mem [8];
  logic [2:0] addr_q;
  // Read data is only valid with an instruction; otherwise it shows a changed value.
  assign o_mem_rdata = i_op_valid ? mem[i_addr] : ~mem[i_addr];
  // The write lands at the byte that the writing instruction addressed.
  always_ff @(posedge i_clk) begin
    if (i_op_valid) begin
      addr_q <= i_addr;
    end
    if (i_mem_wr) begin
      mem[addr_q] <= i_mem_wdata;
    end
  end
endmodule
`default_nettype wire

// file: dv/subtract_swap_skip_datapath_test.sv
// Self-checking testbench of the subtract, swap and skip datapath.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin n_errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, a); end end
module subtract_swap_skip_datapath_test;
  logic i_clk, i_rstn = 0, i_op_valid = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
  logic [2:0] i_op = 0, i_bit_sel = 0, addr = 0;
  logic [7:0] i_imm = 0, rdata, wdata, wreg;
  logic [11:0] i_paddr = 0;
  logic [31:0] i_pwdata = 0, prdata, q;
  logic skip, ready, mem_wr, pready, pslverr, err;
  logic [3:0] flags;
  int n_errors = 0;
  int compares = 0;
  ssd_datapath DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_op_valid(i_op_valid), .i_op(i_op),
    .i_bit_sel(i_bit_sel), .i_imm(i_imm), .i_mem_rdata(rdata), .o_op_ready(ready),
    .o_skip(skip), .o_mem_wr(mem_wr), .o_mem_wdata(wdata), .o_working_register(wreg),
    .o_flags(flags), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr));
  ssd_mem_model mem (.i_clk(i_clk), .i_op_valid(i_op_valid), .i_addr(addr),
    .i_mem_wr(mem_wr), .i_mem_wdata(wdata), .o_mem_rdata(rdata));
  initial begin
    i_clk = 0;
    forever #2.5 i_clk = ~i_clk;
  end
  task automatic test_done;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // One APB transfer; waits for the slave answer.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk);
    i_penable <= 1'b1;
    do @(posedge i_clk); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  // One instruction; returns 1 ns after the edge that registers its results, before any memory write lands.
  task automatic run(input logic [2:0] op, input logic [2:0] b, input logic [2:0] a,
                     input logic [7:0] imm);
    @(posedge i_clk);
    i_op_valid <= 1'b1;
    i_op <= op;
    i_bit_sel <= b;
    addr <= a;
    i_imm <= imm;
    @(posedge i_clk);
    i_op_valid <= 1'b0;
    #1;
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (2) @(posedge i_clk);
    `CHK("reset flags", 4'h0, flags)
    mem.mem[0] = 8'h36;
    mem.mem[1] = 8'h01;
    mem.mem[2] = 8'hA5;
    mem.mem[3] = 8'hC3;
    mem.mem[4] = 8'h5A;
    apb(1'b1, ssd_pkg::REG_WORKING, 32'h0000_0035);
    apb(1'b0, 12'h0FC, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    run(ssd_pkg::OP_SUB_MEM, 3'h0, 3'h0, 8'h00);
    `CHK("sub mem w", 8'hFF, wreg)
    `CHK("sub mem flags", 4'h0, flags)
    `CHK("sub mem wr", 1'b0, mem_wr)
    run(ssd_pkg::OP_SUB_IMM, 3'h0, 3'h7, 8'hFF);
    `CHK("sub imm w", 8'h00, wreg)
    `CHK("sub imm flags", 4'h7, flags)
    apb(1'b1, ssd_pkg::REG_WORKING, 32'h0000_0080);
    apb(1'b0, ssd_pkg::REG_WORKING, 32'h0);
    `CHK("read w", 32'h0000_0080, q)
    `CHK("read w err", 1'b0, err)
    run(ssd_pkg::OP_MINUS_INTO_MEMORY, 3'h0, 3'h1, 8'h00);
    `CHK("minus wr", 1'b1, mem_wr)
    `CHK("minus data", 8'h7F, wdata)
    `CHK("minus w", 8'h80, wreg)
    `CHK("minus flags", 4'h9, flags)
    run(ssd_pkg::OP_NIBBLE_EXCHANGE, 3'h0, 3'h2, 8'h00);
    `CHK("swap mem", 8'h36, mem.mem[0])
    `CHK("minus mem", 8'h7F, mem.mem[1])
    `CHK("swap data", 8'h5A, wdata)
    `CHK("swap flags", 4'h9, flags)
    run(ssd_pkg::OP_NIBBLE_EXCHANGE_TO_WORKING, 3'h0, 3'h3, 8'h00);
    `CHK("swapw w", 8'h3C, wreg)
    `CHK("swapw wr", 1'b0, mem_wr)
    `CHK("swap in place", 8'h5A, mem.mem[2])
    for (int i = 0; i < 8; i++) begin
      run(ssd_pkg::OP_SKIP_IF_BIT_SET, 3'(i), 3'h4, 8'h00);
      `CHK("skip", mem.mem[4][i], skip)
      `CHK("ready", ~mem.mem[4][i], ready)
      `CHK("skip flags", 4'h9, flags)
      if (mem.mem[4][i]) begin
        @(posedge i_clk);
        #1;
        `CHK("ready back", 1'b1, ready)
      end
    end
    `CHK("skip mem", 8'hC3, mem.mem[3])
    run(ssd_pkg::OP_SKIP_IF_BIT_SET, 3'h1, 3'h4, 8'h00);
    apb(1'b0, ssd_pkg::REG_STATE, 32'h0);
    `CHK("state last skip", 32'h0000_0002, q)
    apb(1'b0, ssd_pkg::REG_FLAGS, 32'h0);
    `CHK("read flags", 32'h0000_0009, q)
    test_done();
  end
  initial begin
    #20000;
    n_errors++;
    test_done();
  end
endmodule
`default_nettype wire

// file: hw/ssd_datapath.sv
// Subtract, nibble exchange and bit-test skip datapath with an APB register port.
//
// What this block does
// [RL1] A bit-test skip discards the next instruction when the selected bit is one, else runs it.
// [RL2] A taken skip inserts one dummy cycle, so the skip lasts two instruction cycles.
// [RL3] Subtract from memory puts working register minus memory byte into the working register.
// [RL4] Every subtract clears carry when the difference is negative and sets it otherwise.
// [RL5] Minus into memory stores working register minus memory byte back into that byte.
// [RL6] Immediate subtract takes the constant from the instruction and updates the working register.
// [RL7] Nibble exchange swaps the two halves of the memory byte in place and keeps all flags.
// [RL8] Nibble exchange to working loads the swapped byte into the working register only.
// [RL9] Every subtract also updates zero and signed wrap from the 8-bit result, and half carry from the low-nibble borrow.
// [RL10] The skip takes a 3-bit bit selector and leaves every flag unchanged.
`timescale 1ns/1ps
`default_nettype none
module ssd_datapath (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_op_valid,
  input wire logic [2:0] i_op,
  input wire logic [2:0] i_bit_sel,
  input wire logic [7:0] i_imm,
  input wire logic [7:0] i_mem_rdata,
  output logic o_op_ready,
  output logic o_skip,
  output logic o_mem_wr,
  output logic [7:0] o_mem_wdata,
  output logic [7:0] o_working_register,
  output logic [3:0] o_flags,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr
);
  // ---------------------------------------------------------------
  // Decode and arithmetic
  // ---------------------------------------------------------------
  ssd_pkg::ssd_state_t state_q;
  logic [7:0] working_q;
  logic [3:0] flags_q;
  logic accept;
  logic is_sub;
  logic bit_set;
  logic [7:0] operand;
  logic [8:0] diff;
  logic [4:0] half_diff;
  logic [7:0] sub_res;
  logic [7:0] swapped;
  logic [3:0] sub_flags;
  logic apb_wr;
  logic apb_rd_req;
  logic addr_ok;

  assign accept = i_op_valid && (state_q == ssd_pkg::ST_EXEC);
  assign is_sub = (i_op == ssd_pkg::OP_SUB_MEM) || (i_op == ssd_pkg::OP_MINUS_INTO_MEMORY)
      || (i_op == ssd_pkg::OP_SUB_IMM);
  // [RL10] 3-bit bit selector.
  assign bit_set = i_mem_rdata[i_bit_sel];
  // [RL6] Immediate operand select.
  assign operand = (i_op == ssd_pkg::OP_SUB_IMM) ? i_imm : i_mem_rdata;
  assign diff = {1'b0, working_q} - {1'b0, operand};
  assign half_diff = {1'b0, working_q[3:0]} - {1'b0, operand[3:0]};
  assign sub_res = diff[7:0];
  // [RL7] Nibble halves exchanged.
  assign swapped = {i_mem_rdata[3:0], i_mem_rdata[7:4]};

  always_comb begin
    sub_flags = 4'h0;
    // [RL4] Carry means no borrow.
    sub_flags[ssd_pkg::FLAG_CARRY] = ~diff[8];
    // [RL9] Remaining subtract flags.
    sub_flags[ssd_pkg::FLAG_HALF_CARRY] = ~half_diff[4];
    sub_flags[ssd_pkg::FLAG_ZERO] = (sub_res == 8'h00);
    sub_flags[ssd_pkg::FLAG_SIGNED_WRAP] = (working_q[7] ^ operand[7])
        & (working_q[7] ^ sub_res[7]);
  end

  // ---------------------------------------------------------------
  // Skip sequencer
  // ---------------------------------------------------------------
  // [RL2] Dummy cycle after a taken skip.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= ssd_pkg::ST_EXEC;
    end else begin
      case (state_q)
        ssd_pkg::ST_EXEC: begin
          if (accept && (i_op == ssd_pkg::OP_SKIP_IF_BIT_SET) && bit_set) begin
            state_q <= ssd_pkg::ST_DUMMY;
          end
        end
        ssd_pkg::ST_DUMMY: begin
          state_q <= ssd_pkg::ST_EXEC;
        end
        default: begin
          state_q <= ssd_pkg::ST_EXEC;
        end
      endcase
    end
  end

  // [RL1] Discard strobe for a set bit.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_skip <= 1'b0;
      o_op_ready <= 1'b0;
    end else begin
      o_skip <= accept && (i_op == ssd_pkg::OP_SKIP_IF_BIT_SET) && bit_set;
      o_op_ready <= !(accept && (i_op == ssd_pkg::OP_SKIP_IF_BIT_SET) && bit_set);
    end
  end

  // ---------------------------------------------------------------
  // Memory write-back
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_mem_wr <= 1'b0;
      o_mem_wdata <= 8'h00;
    end else begin
      o_mem_wr <= 1'b0;
      if (accept && (i_op == ssd_pkg::OP_MINUS_INTO_MEMORY)) begin
        // [RL5] Difference into memory.
        o_mem_wr <= 1'b1;
        o_mem_wdata <= sub_res;
      end else if (accept && (i_op == ssd_pkg::OP_NIBBLE_EXCHANGE)) begin
        // [RL7] Swap in place.
        o_mem_wr <= 1'b1;
        o_mem_wdata <= swapped;
      end
    end
  end

  // ---------------------------------------------------------------
  // Working register and flags
  // ---------------------------------------------------------------
  assign apb_wr = i_psel && i_penable && o_pready && i_pwrite && !o_pslverr;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      working_q <= ssd_pkg::WORKING_RESET;
    end else if (accept && ((i_op == ssd_pkg::OP_SUB_MEM) || (i_op == ssd_pkg::OP_SUB_IMM))) begin
      // [RL3] Difference into working register.
      working_q <= sub_res;
    end else if (accept && (i_op == ssd_pkg::OP_NIBBLE_EXCHANGE_TO_WORKING)) begin
      // [RL8] Swapped byte into working register.
      working_q <= swapped;
    end else if (apb_wr && (i_paddr == ssd_pkg::REG_WORKING)) begin
      working_q <= i_pwdata[7:0];
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      flags_q <= ssd_pkg::FLAGS_RESET;
    end else if (accept && is_sub) begin
      // [RL4] Subtract flag update.
      flags_q <= sub_flags;
    end else if (apb_wr && (i_paddr == ssd_pkg::REG_FLAGS)) begin
      flags_q <= i_pwdata[3:0];
    end
  end

  assign o_working_register = working_q;
  assign o_flags = flags_q;

  // ---------------------------------------------------------------
  // APB slave, one wait state
  // ---------------------------------------------------------------
  logic last_skip_q;

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      last_skip_q <= 1'b0;
    end else if (accept && (i_op == ssd_pkg::OP_SKIP_IF_BIT_SET)) begin
      last_skip_q <= bit_set;
    end
  end

  assign apb_rd_req = i_psel && i_penable && !o_pready;
  assign addr_ok = (i_paddr == ssd_pkg::REG_WORKING) || (i_paddr == ssd_pkg::REG_FLAGS)
      || (i_paddr == ssd_pkg::REG_STATE);

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      o_pready <= apb_rd_req;
      o_pslverr <= apb_rd_req && !addr_ok;
      o_prdata <= 32'h0000_0000;
      if (apb_rd_req && !i_pwrite) begin
        case (i_paddr)
          ssd_pkg::REG_WORKING: o_prdata <= {24'h00_0000, working_q};
          ssd_pkg::REG_FLAGS: o_prdata <= {28'h000_0000, flags_q};
          ssd_pkg::REG_STATE: begin
            o_prdata[ssd_pkg::STATE_BUSY] <= (state_q == ssd_pkg::ST_DUMMY);
            o_prdata[ssd_pkg::STATE_LAST_SKIP] <= last_skip_q;
          end
          default: o_prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic flags_wr_hit;
  logic sub_go;
  logic skip_go;

  assign flags_wr_hit = apb_wr && (i_paddr == ssd_pkg::REG_FLAGS);
  assign sub_go = accept && is_sub;
  assign skip_go = accept && (i_op == ssd_pkg::OP_SKIP_IF_BIT_SET);

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  AST_SKIP_TAKEN: assert property (skip_go && bit_set |=> o_skip && !o_op_ready) // [RL1]
    else $error("Set bit did not discard the next instruction.");
  AST_SKIP_NOT_TAKEN: assert property (skip_go && !bit_set |=> !o_skip && o_op_ready) // [RL1]
    else $error("Clear bit wrongly discarded the next instruction.");
  AST_SKIP_TWO_CYCLES: assert property (skip_go && bit_set |=> !o_op_ready ##1 o_op_ready) // [RL2]
    else $error("Taken skip did not last exactly two cycles.");
  AST_SUB_MEM: assert property (accept && i_op == ssd_pkg::OP_SUB_MEM
      |=> working_q == $past(sub_res) && !o_mem_wr) // [RL3]
    else $error("Subtract from memory gave a wrong working register.");
  AST_CARRY: assert property (sub_go
      |=> flags_q[ssd_pkg::FLAG_CARRY] == ($past(working_q) >= $past(operand))) // [RL4]
    else $error("Carry does not follow the sign of the difference.");
  AST_MINUS_INTO_MEMORY: assert property (accept && i_op == ssd_pkg::OP_MINUS_INTO_MEMORY
      |=> o_mem_wr && o_mem_wdata == $past(sub_res) && $stable(working_q)) // [RL5]
    else $error("Minus into memory wrote a wrong byte or touched the working register.");
  AST_SUB_IMM: assert property (accept && i_op == ssd_pkg::OP_SUB_IMM
      |=> working_q == 8'($past(working_q) - $past(i_imm))) // [RL6]
    else $error("Immediate subtract gave a wrong working register.");
  AST_SWAP_MEM: assert property (accept && i_op == ssd_pkg::OP_NIBBLE_EXCHANGE && !flags_wr_hit
      |=> o_mem_wr && o_mem_wdata == $past(swapped) && $stable(flags_q)) // [RL7]
    else $error("In-place nibble exchange is wrong or changed a flag.");
  AST_SWAP_WORK: assert property (accept && i_op == ssd_pkg::OP_NIBBLE_EXCHANGE_TO_WORKING
      |=> working_q == $past(swapped) && !o_mem_wr) // [RL8]
    else $error("Nibble exchange to working register is wrong or wrote memory.");
  AST_ZERO_WRAP: assert property (sub_go
      |=> flags_q[ssd_pkg::FLAG_ZERO] == ($past(sub_res) == 8'h00)
      && flags_q[ssd_pkg::FLAG_SIGNED_WRAP] == $past(sub_flags[ssd_pkg::FLAG_SIGNED_WRAP])) // [RL9]
    else $error("Zero or signed wrap flag is wrong after a subtract.");
  AST_SKIP_FLAGS: assert property (skip_go && !flags_wr_hit |=> $stable(flags_q)) // [RL10]
    else $error("Bit-test skip changed a flag.");

  AST_HALF_CARRY: assert property (sub_go
      |=> flags_q[ssd_pkg::FLAG_HALF_CARRY] == ($past(working_q[3:0]) >= $past(operand[3:0]))) // [RL9]
    else $error("Half carry does not follow the low nibble borrow.");
  AST_CARRY_NEG: assert property (sub_go && diff[8] |=> !flags_q[ssd_pkg::FLAG_CARRY]) // [RL4]
    else $error("Negative difference left carry set.");
  AST_SKIP_NO_WRITE: assert property (skip_go |=> !o_mem_wr) // [RL1]
    else $error("Bit-test skip wrote data memory.");
  AST_DUMMY_IGNORED: assert property (state_q == ssd_pkg::ST_DUMMY
      |=> !o_skip && !o_mem_wr && o_op_ready) // [RL2]
    else $error("An instruction was taken during the dummy cycle.");
  AST_SWAP_WORK_FLAGS: assert property (accept && i_op == ssd_pkg::OP_NIBBLE_EXCHANGE_TO_WORKING
      && !flags_wr_hit |=> $stable(flags_q)) // [RL8]
    else $error("Nibble exchange to working register changed a flag.");

  // ---------------------------------------------------------------
  // Register port checks
  // ---------------------------------------------------------------
  AST_PREADY_PULSE: assert property (o_pready |=> !o_pready)
    else $error("Register port ready stood for more than one cycle.");
  AST_PSLVERR_WITH_READY: assert property (o_pslverr |-> o_pready)
    else $error("Register port error without ready.");
  AST_PRDATA_IDLE: assert property (!o_pready |-> o_prdata == 32'h0000_0000)
    else $error("Register port read data not zero outside an answer.");

  // ---------------------------------------------------------------
  // Cover properties
  // ---------------------------------------------------------------
  COV_SKIP_TAKEN: cover property (skip_go && bit_set ##2 accept);
  COV_SUB_NEGATIVE: cover property (sub_go && diff[8]);
  COV_SWAP_MEM: cover property (accept && i_op == ssd_pkg::OP_NIBBLE_EXCHANGE);
  COV_SUB_IMM: cover property (accept && i_op == ssd_pkg::OP_SUB_IMM);
  COV_SWAP_WORK: cover property (accept && i_op == ssd_pkg::OP_NIBBLE_EXCHANGE_TO_WORKING);
endmodule
`default_nettype wire

// file: hw/ssd_pkg.sv
// Constants shared by the subtract, swap and skip datapath.
package ssd_pkg;
  // ---------------------------------------------------------------
  // Operation codes presented by the instruction decoder
  // ---------------------------------------------------------------
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_SKIP_IF_BIT_SET = 3'h1;
  localparam logic [2:0] OP_SUB_MEM = 3'h2;
  localparam logic [2:0] OP_MINUS_INTO_MEMORY = 3'h3;
  localparam logic [2:0] OP_SUB_IMM = 3'h4;
  localparam logic [2:0] OP_NIBBLE_EXCHANGE = 3'h5;
  localparam logic [2:0] OP_NIBBLE_EXCHANGE_TO_WORKING = 3'h6;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] REG_WORKING = 12'h000;
  localparam logic [11:0] REG_FLAGS = 12'h004;
  localparam logic [11:0] REG_STATE = 12'h008;
  // ---------------------------------------------------------------
  // Flag and state bit positions and reset values
  // ---------------------------------------------------------------
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_HALF_CARRY = 1;
  localparam int FLAG_ZERO = 2;
  localparam int FLAG_SIGNED_WRAP = 3;
  localparam int STATE_BUSY = 0;
  localparam int STATE_LAST_SKIP = 1;
  localparam logic [7:0] WORKING_RESET = 8'h00;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic {ST_EXEC, ST_DUMMY} ssd_state_t;
endpackage
